// ### common/cmbf_pkg.sv
`default_nettype none
// ==========================================================================
// core memory bus fabric constants
package cmbf_pkg;
  localparam int PAB_W    = 21;  // program address width
  localparam int XAB_W    = 24;  // data address width
  localparam int WIDE_W   = 32;  // primary data ram port width
  localparam int NARROW_W = 16;  // every other data port
  localparam int ADDR_MSB = 23;  // bit cleared for byte accesses

  // region decode on the data address, base and mask
  localparam logic [23:0] PERIPH_BASE = 24'h00F000;
  localparam logic [23:0] PERIPH_MASK = 24'hFFF000;
  localparam logic [23:0] DFLASH_BASE = 24'h008000;
  localparam logic [23:0] DFLASH_MASK = 24'hFF8000;

  // fixed latency, request edge to read data edge
  localparam int RD_LATENCY = 2;

  typedef enum logic [1:0] {
    CMBF_SZ_BYTE = 2'h0,
    CMBF_SZ_WORD = 2'h1,
    CMBF_SZ_LONG = 2'h2
  } cmbf_size_t;
endpackage : cmbf_pkg
`default_nettype wire

// ### dv/cmbf_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// memory and peripheral targets behind the fabric
module cmbf_mem_model (
  input  wire logic        core_clk,
  input  wire logic        pm_en,
  input  wire logic [20:0] pm_addr,
  output logic      [15:0] pm_rdata,
  input  wire logic        dr_en,
  input  wire logic [23:0] dr_addr,
  output logic      [31:0] dr_rdata,
  input  wire logic        df_en,
  input  wire logic [23:0] df_addr,
  output logic      [15:0] df_rdata,
  input  wire logic        ds_en,
  input  wire logic [23:0] ds_addr,
  output logic      [15:0] ds_rdata,
  input  wire logic        prb_rd,
  input  wire logic [23:0] prb_addr,
  output logic      [15:0] prb_rdata
);
  logic [15:0] junk_r;

  // junk moves every cycle, so a sample outside a strobe never matches
  initial junk_r = 16'h0000;
  always @(posedge core_clk) junk_r <= junk_r + 16'h1357;

  // each target answers only while its strobe is high
  assign pm_rdata  = pm_en  ? ~pm_addr[15:0]               : junk_r;
  assign dr_rdata  = dr_en  ? {dr_addr[15:0], ~dr_addr[15:0]} : {2{junk_r}};
  assign df_rdata  = df_en  ? df_addr[15:0] ^ 16'h5A5A      : junk_r;
  assign ds_rdata  = ds_en  ? ds_addr[15:0] ^ 16'h3C3C      : junk_r;
  assign prb_rdata = prb_rd ? prb_addr[15:0] ^ 16'hC3C3     : ~junk_r;
endmodule : cmbf_mem_model
`default_nettype wire

// ### dv/core_memory_bus_fabric_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench for the core memory bus fabric
module core_memory_bus_fabric_tb;
  import cmbf_pkg::*;
  logic        core_clk, sys_rst, prog_req, prog_wr, pri_req, pri_wr, sec_req;
  logic        prog_rvalid, pri_rvalid, sec_rvalid, pm_en, pm_we, dr_en, dr_we;
  logic        df_en, df_we, ds_en, prb_rd, prb_wr;
  logic [1:0]  pri_size, dr_size;
  logic [20:0] prog_addr, pm_addr;
  logic [23:0] primary_data_address, secondary_data_address, dr_addr, df_addr;
  logic [23:0] ds_addr, prb_addr;
  logic [15:0] prog_rdata, secondary_read_bus, pm_wdata, pm_rdata, df_wdata;
  logic [15:0] df_rdata, ds_rdata, prb_wdata, prb_rdata;
  logic [31:0] pri_wdata, pri_rdata, dr_wdata, dr_rdata, exp_rd;
  int          errors, checks;

  cmbf_fabric    cmbf_fabric_i (.*);
  cmbf_mem_model cmbf_mem_model_i (.*);

  // ==========================================================================
  // clock and shared tasks
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic cmp(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // called at a falling edge; t: 0 data ram, 1 data flash, 2 peripheral
  task automatic pri_go(input logic wr, input logic [1:0] sz,
                        input logic [23:0] a, input logic [31:0] wd,
                        input int t);
    logic [23:0] ea;
    ea = (sz == CMBF_SZ_BYTE) ? {1'b0, a[22:0]} : a;
    pri_req = 1'b1;
    pri_wr = wr;
    pri_size = sz;
    primary_data_address = a;
    pri_wdata = wd;
    @(negedge core_clk);
    {prog_req, pri_req, sec_req} = 3'h0;
    cmp("dr_strobe", {t == 0, t == 0 && wr}, {dr_en, dr_we});
    cmp("df_strobe", {t == 1, t == 1 && wr}, {df_en, df_we});
    cmp("prb_stb", {t == 2 && !wr, t == 2 && wr}, {prb_rd, prb_wr});
    case (t)
      0: begin
        cmp("dr_addr", ea, dr_addr);
        cmp("dr_size", sz, dr_size);
        if (wr) cmp("dr_wdata", wd, dr_wdata);
        exp_rd = {ea[15:0], ~ea[15:0]};
      end
      1: begin
        cmp("df_addr", ea, df_addr);
        if (wr) cmp("df_wdata", wd[15:0], df_wdata);
        exp_rd = {16'h0000, ea[15:0] ^ 16'h5A5A};
      end
      default: begin
        cmp("prb_addr", ea, prb_addr);
        if (wr) cmp("prb_wdata", wd[15:0], prb_wdata);
        exp_rd = {16'h0000, ea[15:0] ^ 16'hC3C3};
      end
    endcase
  endtask : pri_go

  // every target answers two edges after the request, no wait states
  task automatic pri_end(input logic wr);
    @(negedge core_clk);
    cmp("pri_rvalid", !wr, pri_rvalid);
    if (!wr) cmp("pri_rdata", exp_rd, pri_rdata);
  endtask : pri_end

  task automatic pri_op(input logic wr, input logic [1:0] sz,
                        input logic [23:0] a, input logic [31:0] wd,
                        input int t);
    pri_go(wr, sz, a, wd, t);
    pri_end(wr);
  endtask : pri_op

  // ==========================================================================
  // scenarios
  task automatic t_dual();
    prog_req = 1'b1;
    prog_wr = 1'b0;
    prog_addr = 21'h1ABCDE;
    sec_req = 1'b1;
    secondary_data_address = 24'h001236;
    pri_go(1'b0, CMBF_SZ_LONG, 24'h004400, 32'h0, 0);
    cmp("pm", {2'h2, 21'h1ABCDE}, {pm_en, pm_we, pm_addr});
    cmp("ds", {1'b1, 24'h001236}, {ds_en, ds_addr});
    pri_end(1'b0);
    cmp("prog_rd", {1'b1, 16'h4321}, {prog_rvalid, prog_rdata});
    cmp("sec", {1'b1, 16'h2E0A}, {sec_rvalid, secondary_read_bus});
    $display("t_dual done");
  endtask : t_dual

  // upper write bits must not leak into program memory
  task automatic t_prog_wr();
    prog_req = 1'b1;
    prog_wr = 1'b1;
    prog_addr = 21'h000123;
    pri_wdata = 32'hFFFF1234;
    @(negedge core_clk);
    prog_req = 1'b0;
    cmp("pm_cmd", {2'h3, 21'h000123}, {pm_en, pm_we, pm_addr});
    cmp("pm_wdata", 16'h1234, pm_wdata);
    @(negedge core_clk);
    cmp("prog_rvalid", 1'b0, prog_rvalid);
    $display("t_prog_wr done");
  endtask : t_prog_wr

  task automatic t_sizes();
    for (int s = 0; s < 3; s++) begin
      pri_op(1'b1, s[1:0], 24'h812346, 32'hA1B2C3D4, 0);
      pri_op(1'b0, s[1:0], 24'h812346, 32'h0, 0);
    end
    $display("t_sizes done");
  endtask : t_sizes

  // byte msb forcing moves this address into the peripheral window
  task automatic t_periph();
    pri_op(1'b0, CMBF_SZ_BYTE, 24'h80F010, 32'h0, 2);
    pri_op(1'b1, CMBF_SZ_WORD, 24'h00F020, 32'hBEEF5A01, 2);
    pri_op(1'b0, CMBF_SZ_WORD, 24'h00F020, 32'h0, 2);
    $display("t_periph done");
  endtask : t_periph

  task automatic t_flash();
    pri_op(1'b1, CMBF_SZ_WORD, 24'h008010, 32'h77776543, 1);
    pri_op(1'b0, CMBF_SZ_WORD, 24'h008010, 32'h0, 1);
    $display("t_flash done");
  endtask : t_flash

  // secondary path never reaches peripheral or flash, answers zero
  task automatic t_sec_refuse();
    logic [23:0] sa [2] = '{24'h00F030, 24'h008020};
    for (int i = 0; i < 2; i++) begin
      sec_req = 1'b1;
      secondary_data_address = sa[i];
      @(negedge core_clk);
      sec_req = 1'b0;
      cmp("sec_strobes", 3'h0, {ds_en, prb_rd, df_en});
      @(negedge core_clk);
      cmp("sec_rd", {1'b1, 16'h0}, {sec_rvalid, secondary_read_bus});
    end
    $display("t_sec_refuse done");
  endtask : t_sec_refuse

  // reset in mid-run kills a pending read; first request right after release
  task automatic t_reset();
    prog_req = 1'b1;
    prog_wr = 1'b0;
    prog_addr = 21'h000456;
    @(negedge core_clk);
    prog_req = 1'b0;
    sys_rst = 1'b1;
    @(negedge core_clk);
    cmp("rst", 4'h0, {pm_en, prog_rvalid, pri_rvalid, sec_rvalid});
    cmp("rst_rdata", 16'h0000, prog_rdata);
    sys_rst = 1'b0;
    prog_req = 1'b1;
    @(negedge core_clk);
    prog_req = 1'b0;
    cmp("rst_pm", {2'h2, 21'h000456}, {pm_en, pm_we, pm_addr});
    @(negedge core_clk);
    cmp("rst_rd", {1'b1, 16'hFBA9}, {prog_rvalid, prog_rdata});
    $display("t_reset done");
  endtask : t_reset

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    {sys_rst, prog_req, prog_wr, pri_req, pri_wr, sec_req} = 6'h20;
    {prog_addr, pri_size, primary_data_address} = '0;
    {pri_wdata, secondary_data_address} = '0;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    t_dual();
    t_prog_wr();
    t_sizes();
    t_periph();
    t_flash();
    t_sec_refuse();
    t_reset();
    final_report();
  end

  initial begin
    #50000;
    errors++;
    final_report();
  end
endmodule : core_memory_bus_fabric_tb
`default_nettype wire

// ### hdl/cmbf_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// data address decode, shared by the primary and secondary paths
module cmbf_decode
  import cmbf_pkg::*;
(
  input  wire logic [23:0] addr,
  input  wire logic [1:0]  size,
  output logic      [23:0] addr_fix,
  output logic             is_periph,
  output logic             is_flash,
  output logic             is_ram
);
  // byte accesses live in the lower half only
  always_comb begin
    addr_fix = addr;
    if (size == CMBF_SZ_BYTE) begin
      addr_fix[ADDR_MSB] = 1'b0; // RULE6
    end
    is_periph = (addr_fix & PERIPH_MASK) == PERIPH_BASE;
    is_flash  = ((addr_fix & DFLASH_MASK) == DFLASH_BASE) && !is_periph;
    is_ram    = !is_periph && !is_flash;
  end
endmodule : cmbf_decode
`default_nettype wire

// ### hdl/cmbf_fabric.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// RULE1: program path takes a 21-bit address and returns 16-bit words.
// RULE2: program writes use only the low 16 bits of the primary write bus.
// RULE3: primary port has a 24-bit byte/word/long address, 32-bit buses.
// RULE4: peripheral registers are reached only via the primary address.
// RULE5: secondary port serves the second read, words only, 16-bit data.
// RULE6: every byte access has its address msb forced to zero.
// RULE7: the peripheral bus adds no wait states over data ram timing.
// RULE8: peripheral writes take primary write data, reads feed primary.
// RULE9: primary data ram port is 32 bits, all other ports are 16 bits.
// RULE10: flash control goes over the peripheral bus, data goes direct.
// RULE11: program, primary and secondary accesses run in the same cycle.
module cmbf_fabric
  import cmbf_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // core program side
  input  wire logic        prog_req,
  input  wire logic        prog_wr,
  input  wire logic [20:0] prog_addr,
  output logic             prog_rvalid,
  output logic      [15:0] prog_rdata,
  // core primary data side
  input  wire logic        pri_req,
  input  wire logic        pri_wr,
  input  wire logic [1:0]  pri_size,
  input  wire logic [23:0] primary_data_address,
  input  wire logic [31:0] pri_wdata,
  output logic             pri_rvalid,
  output logic      [31:0] pri_rdata,
  // core secondary data side
  input  wire logic        sec_req,
  input  wire logic [23:0] secondary_data_address,
  output logic             sec_rvalid,
  output logic      [15:0] secondary_read_bus,
  // program memory
  output logic             pm_en,
  output logic             pm_we,
  output logic      [20:0] pm_addr,
  output logic      [15:0] pm_wdata,
  input  wire logic [15:0] pm_rdata,
  // primary data ram port
  output logic             dr_en,
  output logic             dr_we,
  output logic      [1:0]  dr_size,
  output logic      [23:0] dr_addr,
  output logic      [31:0] dr_wdata,
  input  wire logic [31:0] dr_rdata,
  // data flash array
  output logic             df_en,
  output logic             df_we,
  output logic      [23:0] df_addr,
  output logic      [15:0] df_wdata,
  input  wire logic [15:0] df_rdata,
  // secondary data ram port
  output logic             ds_en,
  output logic      [23:0] ds_addr,
  input  wire logic [15:0] ds_rdata,
  // peripheral register bus
  output logic             prb_rd,
  output logic             prb_wr,
  output logic      [23:0] prb_addr,
  output logic      [15:0] prb_wdata,
  input  wire logic [15:0] prb_rdata
);
  // ========================================================================
  // state
  typedef struct packed {
    logic        pm_en;
    logic        pm_we;
    logic [20:0] pm_addr;
    logic [15:0] pm_wdata;
    logic        dr_en;
    logic        dr_we;
    logic [1:0]  dr_size;
    logic [23:0] dr_addr;
    logic [31:0] dr_wdata;
    logic        df_en;
    logic        df_we;
    logic [23:0] df_addr;
    logic [15:0] df_wdata;
    logic        ds_en;
    logic        sec_nil;
    logic [23:0] ds_addr;
    logic        prb_rd;
    logic        prb_wr;
    logic [23:0] prb_addr;
    logic [15:0] prb_wdata;
    logic        prog_rvalid;
    logic [15:0] prog_rdata;
    logic        pri_rvalid;
    logic [31:0] pri_rdata;
    logic        sec_rvalid;
    logic [15:0] sec_rdata;
  } cmbf_state_t;
  cmbf_state_t st_r;
  cmbf_state_t st_nxt;
  logic [23:0] pri_fix;
  logic        pri_periph;
  logic        pri_flash;
  logic        pri_ram;
  logic [23:0] sec_fix;
  logic        sec_periph;
  logic        sec_flash;
  logic        sec_ram;

  // ========================================================================
  // decode
  cmbf_decode u_pri_dec (
    .addr      (primary_data_address),
    .size      (pri_size),
    .addr_fix  (pri_fix),
    .is_periph (pri_periph),
    .is_flash  (pri_flash),
    .is_ram    (pri_ram)
  );
  // secondary is word only, so its msb is never forced
  cmbf_decode u_sec_dec (
    .addr      (secondary_data_address),
    .size      (CMBF_SZ_WORD),
    .addr_fix  (sec_fix),
    .is_periph (sec_periph),
    .is_flash  (sec_flash),
    .is_ram    (sec_ram)
  );

  // ========================================================================
  // next state: issue stage then return stage, three paths in parallel
  always_comb begin
    st_nxt = st_r;
    // strobes are single cycle, addresses and data just hold
    st_nxt.pm_en       = 1'b0;
    st_nxt.pm_we       = 1'b0;
    st_nxt.dr_en       = 1'b0;
    st_nxt.dr_we       = 1'b0;
    st_nxt.df_en       = 1'b0;
    st_nxt.df_we       = 1'b0;
    st_nxt.ds_en       = 1'b0;
    st_nxt.sec_nil     = 1'b0;
    st_nxt.prb_rd      = 1'b0;
    st_nxt.prb_wr      = 1'b0;
    st_nxt.prog_rvalid = 1'b0;
    st_nxt.pri_rvalid  = 1'b0;
    st_nxt.sec_rvalid  = 1'b0;
    // program path
    if (prog_req) begin
      st_nxt.pm_en    = 1'b1; // RULE11
      st_nxt.pm_we    = prog_wr;
      st_nxt.pm_addr  = prog_addr; // RULE1
      st_nxt.pm_wdata = pri_wdata[15:0]; // RULE2
    end
    // primary path, steered by region
    if (pri_req && pri_ram) begin
      st_nxt.dr_en    = 1'b1; // RULE3
      st_nxt.dr_we    = pri_wr;
      st_nxt.dr_size  = pri_size;
      st_nxt.dr_addr  = pri_fix; // RULE6
      st_nxt.dr_wdata = pri_wdata; // RULE9
    end
    if (pri_req && pri_flash) begin
      // array data goes direct; control regs sit in the periph window
      st_nxt.df_en    = 1'b1; // RULE10
      st_nxt.df_we    = pri_wr;
      st_nxt.df_addr  = pri_fix;
      st_nxt.df_wdata = pri_wdata[15:0];
    end
    if (pri_req && pri_periph) begin
      st_nxt.prb_rd    = !pri_wr; // RULE4
      st_nxt.prb_wr    = pri_wr;
      st_nxt.prb_addr  = pri_fix;
      st_nxt.prb_wdata = pri_wdata[15:0]; // RULE8
    end
    // secondary path reaches data ram only; other regions read as zero
    if (sec_req) begin
      st_nxt.ds_en   = sec_ram; // RULE5
      st_nxt.sec_nil = !sec_ram; // RULE4
      st_nxt.ds_addr = sec_fix;
    end
    // return stage, same latency for every target
    if (st_r.pm_en && !st_r.pm_we) begin
      st_nxt.prog_rvalid = 1'b1;
      st_nxt.prog_rdata  = pm_rdata; // RULE1
    end
    if (st_r.dr_en && !st_r.dr_we) begin
      st_nxt.pri_rvalid = 1'b1;
      st_nxt.pri_rdata  = dr_rdata; // RULE3
    end else if (st_r.df_en && !st_r.df_we) begin
      st_nxt.pri_rvalid = 1'b1;
      st_nxt.pri_rdata  = {16'h0000, df_rdata}; // RULE9
    end else if (st_r.prb_rd) begin
      st_nxt.pri_rvalid = 1'b1; // RULE7
      st_nxt.pri_rdata  = {16'h0000, prb_rdata}; // RULE8
    end
    if (st_r.ds_en) begin
      st_nxt.sec_rvalid = 1'b1;
      st_nxt.sec_rdata  = ds_rdata; // RULE5
    end else if (st_r.sec_nil) begin
      st_nxt.sec_rvalid = 1'b1;
      st_nxt.sec_rdata  = 16'h0000;
    end
  end

  // ========================================================================
  // state register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // outputs straight from the state flops
  assign pm_en              = st_r.pm_en;
  assign pm_we              = st_r.pm_we;
  assign pm_addr            = st_r.pm_addr;
  assign pm_wdata           = st_r.pm_wdata;
  assign dr_en              = st_r.dr_en;
  assign dr_we              = st_r.dr_we;
  assign dr_size            = st_r.dr_size;
  assign dr_addr            = st_r.dr_addr;
  assign dr_wdata           = st_r.dr_wdata;
  assign df_en              = st_r.df_en;
  assign df_we              = st_r.df_we;
  assign df_addr            = st_r.df_addr;
  assign df_wdata           = st_r.df_wdata;
  assign ds_en              = st_r.ds_en;
  assign ds_addr            = st_r.ds_addr;
  assign prb_rd             = st_r.prb_rd;
  assign prb_wr             = st_r.prb_wr;
  assign prb_addr           = st_r.prb_addr;
  assign prb_wdata          = st_r.prb_wdata;
  assign prog_rvalid        = st_r.prog_rvalid;
  assign prog_rdata         = st_r.prog_rdata;
  assign pri_rvalid         = st_r.pri_rvalid;
  assign pri_rdata          = st_r.pri_rdata;
  assign sec_rvalid         = st_r.sec_rvalid;
  assign secondary_read_bus = st_r.sec_rdata;

  // ========================================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_prog_read_return: assert property ( // RULE1
    prog_req && !prog_wr |=> pm_en && !pm_we
      ##1 prog_rvalid && prog_rdata == $past(pm_rdata))
    else $error("program read not returned in two cycles");
  a_prog_write_low: assert property ( // RULE2
    prog_req && prog_wr |=> pm_we && pm_wdata == $past(pri_wdata[15:0]))
    else $error("program write data not low half of write bus");
  a_pri_ram_read: assert property ( // RULE3
    pri_req && !pri_wr && pri_ram |=> dr_en && dr_addr == $past(pri_fix)
      ##1 pri_rvalid && pri_rdata == $past(dr_rdata))
    else $error("primary ram read wrong address or data");
  a_periph_via_pri: assert property ( // RULE4
    // a primary peripheral read in the same cycle may legally strobe prb_rd
    sec_req && (sec_periph || sec_flash) |=> !ds_en
      && (!prb_rd || $past(pri_periph))
      ##1 sec_rvalid && secondary_read_bus == 16'h0000)
    else $error("secondary access leaked out of data ram");
  a_sec_word_read: assert property ( // RULE5
    sec_req && sec_ram |=> ds_en ##1 sec_rvalid
      && secondary_read_bus == $past(ds_rdata))
    else $error("secondary read not served");
  a_byte_msb_zero: assert property ( // RULE6
    (dr_en && dr_size == CMBF_SZ_BYTE) |-> !dr_addr[ADDR_MSB])
    else $error("byte access above lower half");
  a_periph_no_wait: assert property ( // RULE7
    pri_req && !pri_wr && pri_periph |=> prb_rd ##1 pri_rvalid
      && pri_rdata == {16'h0000, $past(prb_rdata)})
    else $error("peripheral read latency differs from ram");
  a_periph_wdata: assert property ( // RULE8
    pri_req && pri_wr && pri_periph |=> prb_wr && !dr_en
      && prb_wdata == $past(pri_wdata[15:0]))
    else $error("peripheral write data not from primary bus");
  a_narrow_zero_ext: assert property ( // RULE9
    df_en && !df_we |=> pri_rvalid && pri_rdata[31:16] == 16'h0000)
    else $error("narrow read not zero extended");
  a_flash_direct: assert property ( // RULE10
    pri_req && pri_flash |=> df_en && !prb_rd && !prb_wr)
    else $error("flash data routed over peripheral bus");
  a_three_parallel: assert property ( // RULE11
    prog_req && pri_req && pri_ram && sec_req && sec_ram
      |=> pm_en && dr_en && ds_en)
    else $error("parallel accesses not issued together");
  c_triple_read: cover property (
    prog_req && !prog_wr && pri_req && !pri_wr && pri_ram && sec_req);
  c_periph_read: cover property (prb_rd ##1 pri_rvalid);
  c_byte_forced: cover property (
    pri_req && pri_size == CMBF_SZ_BYTE && primary_data_address[ADDR_MSB]);
  c_flash_write: cover property (df_en && df_we);
endmodule : cmbf_fabric
`default_nettype wire
